/* File: hdl/mtc_tx_config.sv */
`timescale 1ns/1ps

// Behaviour
// - Enable bit clear puts transmitter in stop mode; no transmission.
// - tx_control resets to 10H; fields at bits 7,4,1,0; others zero.
// - First-bit order: 0 selects MSB first, 1 selects LSB first.
// - Output format: 0 Manchester, 1 plain bit-sequential output.
// - Suspended output holds the idle level field value.
// - tx_control takes bit and byte writes; others byte writes only.
// - base_clock_select resets to 00H; 3-bit select, upper bits zero.
// - Base clock is peripheral clock over 2^sel; codes 6,7 prohibited.
// - baud_divisor resets to 1FH; 5-bit field, upper bits zero.
// - Counter divides base clock by k; values 0 to 4 give 4.
// - Baud clock is counter output halved: rate base over 2k.
// - Reset or clearing enable clears the status register.
// - Manchester output is shift bit XOR baud clock.
module mtc_tx_config (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Processor access.
  input wire mtc_pkg::mtc_busreq_t busReq,
  output logic [7:0] busRdata,
  // Shift path.
  input wire logic shiftBit,
  input wire logic txActive,
  output logic opEnable,
  output logic firstBitLsb,
  output logic baudClk,
  output logic baudTick,
  // Serial line.
  output logic codedSerialOut
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] kDecode(input logic [4:0] field);
    kDecode = (field < mtc_pkg::DIVISOR_MIN) ? mtc_pkg::K_FLOOR : field;
  endfunction

  function automatic logic [4:0] selMask(input logic [2:0] sel);
    selMask = ~(mtc_pkg::PRESC_ONES << sel);
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] txControl_r;
  logic [7:0] txControl_nxt;
  logic [7:0] baseSel_r;
  logic [7:0] baseSel_nxt;
  logic [7:0] divisor_r;
  logic [7:0] divisor_nxt;
  logic txFlag_r;
  logic [4:0] presc_r;
  logic [4:0] kCnt_r;
  logic baudClk_r;
  logic baudTick_r;
  logic serialOut_r;
  logic [7:0] rdata_r;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  wire hitCtl0 = busReq.addr == mtc_pkg::TX_CONTROL_ADDR;
  wire hitCtl1 = busReq.addr == mtc_pkg::BASE_CLOCK_SELECT_ADDR;
  wire hitCtl2 = busReq.addr == mtc_pkg::BAUD_DIVISOR_ADDR;
  wire hitStat = busReq.addr == mtc_pkg::TX_STATUS_ADDR;
  wire byteWr0 = busReq.wr && hitCtl0;
  wire bitWr0 = busReq.bitWr && !busReq.wr && hitCtl0;
  wire byteWr1 = busReq.wr && hitCtl1;
  wire byteWr2 = busReq.wr && hitCtl2;
  wire [7:0] bitOne = 8'h01 << busReq.bitSel;
  wire [7:0] bitMerged = busReq.bitVal ? (txControl_r | bitOne)
                                       : (txControl_r & ~bitOne);

  // Bit writes reach tx_control only; masks drop fixed-zero bits.
  wire [7:0] byteCtl0 = busReq.wdata & mtc_pkg::TX_CONTROL_MASK;
  wire [7:0] bitCtl0 = bitMerged & mtc_pkg::TX_CONTROL_MASK;
  wire [7:0] byteCtl1 = busReq.wdata & mtc_pkg::BASE_CLOCK_SELECT_MASK;
  wire [7:0] byteCtl2 = busReq.wdata & mtc_pkg::BAUD_DIVISOR_MASK;
  assign txControl_nxt = byteWr0 ? byteCtl0
                       : bitWr0 ? bitCtl0
                       : txControl_r;
  assign baseSel_nxt = byteWr1 ? byteCtl1 : baseSel_r;
  assign divisor_nxt = byteWr2 ? byteCtl2 : divisor_r;

  wire enable = txControl_r[mtc_pkg::OP_ENABLE_BIT];
  wire plainFmt = txControl_r[mtc_pkg::OUTPUT_FORMAT_BIT];
  wire idleLevel = txControl_r[mtc_pkg::IDLE_LEVEL_BIT];
  wire [7:0] statusVal = {txFlag_r, 7'h00};

  wire [7:0] readMux = hitCtl0 ? txControl_r
                     : hitCtl1 ? baseSel_r
                     : hitCtl2 ? divisor_r
                     : hitStat ? statusVal
                     : 8'h00;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      txControl_r <= mtc_pkg::TX_CONTROL_RST;
      baseSel_r <= mtc_pkg::BASE_CLOCK_SELECT_RST;
      divisor_r <= mtc_pkg::BAUD_DIVISOR_RST;
      rdata_r <= 8'h00;
    end else begin
      txControl_r <= txControl_nxt;
      baseSel_r <= baseSel_nxt;
      divisor_r <= divisor_nxt;
      rdata_r <= busReq.rd ? readMux : rdata_r;
    end
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      txFlag_r <= 1'b0;
    end else if (!enable) begin
      txFlag_r <= 1'b0;
    end else begin
      txFlag_r <= txActive;
    end
  end

  // ---------------------------------------------------------------
  // Baud generation
  // ---------------------------------------------------------------
  wire [2:0] selCode = baseSel_r[2:0];
  wire selLegal = selCode <= mtc_pkg::BASE_SEL_MAX;
  wire [4:0] mask = selMask(selCode);
  // Prohibited select codes produce no base ticks at all.
  wire baseTick = enable && selLegal && ((presc_r & mask) == mask);
  wire [4:0] kVal = kDecode(divisor_r[4:0]);
  wire kWrap = kCnt_r == (kVal - mtc_pkg::CNT_ONE);

  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      presc_r <= 5'h00;
      kCnt_r <= 5'h00;
      baudClk_r <= 1'b0;
      baudTick_r <= 1'b0;
    end else begin
      presc_r <= presc_r + mtc_pkg::CNT_ONE;
      baudTick_r <= baseTick && kWrap && !baudClk_r;
      if (baseTick) begin
        kCnt_r <= kWrap ? 5'h00 : kCnt_r + mtc_pkg::CNT_ONE;
        baudClk_r <= kWrap ? !baudClk_r : baudClk_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  wire sending = enable && txActive;
  wire dataLevel = plainFmt ? shiftBit
                            : (shiftBit ^ baudClk_r);
  wire outNxt = sending ? dataLevel : idleLevel;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      serialOut_r <= 1'b0;
    end else begin
      serialOut_r <= outNxt;
    end
  end

  assign busRdata = rdata_r;
  assign opEnable = enable;
  assign firstBitLsb = txControl_r[mtc_pkg::FIRST_BIT_ORDER_BIT];
  assign baudClk = baudClk_r;
  assign baudTick = baudTick_r;
  assign codedSerialOut = serialOut_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Every check below runs on the core clock and rests during reset.
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  stop_mode_idle_a: assert property (
    !enable |=> codedSerialOut == $past(idleLevel))
    else $error("stop mode output not at idle level");

  stop_no_baud_a: assert property (
    !enable |=> !baudClk && kCnt_r == 5'h00)
    else $error("baud logic runs in stop mode");

  stop_presc_a: assert property (
    !enable |=> presc_r == 5'h00)
    else $error("prescaler runs in stop mode");

  ctl0_zero_bits_a: assert property (
    (txControl_r & ~mtc_pkg::TX_CONTROL_MASK) == 8'h00)
    else $error("tx_control fixed-zero bit set");

  // The first edge after reset is the one that sees the reset values.
  reset_values_a: assert property (
    $past(srst) |-> txControl_r == mtc_pkg::TX_CONTROL_RST
      && baseSel_r == mtc_pkg::BASE_CLOCK_SELECT_RST
      && divisor_r == mtc_pkg::BAUD_DIVISOR_RST && !txFlag_r)
    else $error("register reset value wrong");

  read_ctl0_a: assert property (
    busReq.rd && hitCtl0 |=> busRdata == $past(txControl_r))
    else $error("tx_control read data wrong");

  order_follows_a: assert property (
    byteWr0 |=> firstBitLsb ==
      $past(busReq.wdata[mtc_pkg::FIRST_BIT_ORDER_BIT]))
    else $error("first bit order not taken");

  plain_output_a: assert property (
    sending && plainFmt |=> codedSerialOut == $past(shiftBit))
    else $error("plain output differs from shift bit");

  idle_hold_a: assert property (
    enable && !txActive |=> codedSerialOut == $past(idleLevel))
    else $error("suspended output not at idle level");

  ctl1_bitwr_a: assert property (
    busReq.bitWr && !busReq.wr && (hitCtl1 || hitCtl2)
      |=> $stable(baseSel_r) && $stable(divisor_r))
    else $error("bit write changed a byte-only register");

  ctl0_bitwr_a: assert property (
    bitWr0 && busReq.bitSel == 3'h7
      |=> enable == $past(busReq.bitVal))
    else $error("bit write to enable lost");

  upper_zero_a: assert property (
    baseSel_r[7:3] == 5'h00 && divisor_r[7:5] == 3'h0)
    else $error("upper register bits not zero");

  fast_base_a: assert property (
    enable && selCode == 3'h0 |-> baseTick)
    else $error("undivided base clock missing tick");

  prohibited_a: assert property (
    !selLegal |-> !baseTick)
    else $error("prohibited select produced ticks");

  k_floor_a: assert property (
    divisor_r[4:0] < mtc_pkg::DIVISOR_MIN |-> kVal == mtc_pkg::K_FLOOR)
    else $error("small divisor not raised to four");

  // Holds as long as software leaves the divisor alone while enabled.
  k_range_a: assert property (
    kCnt_r < kVal)
    else $error("divisor counter beyond k");

  baud_toggle_a: assert property (
    enable && $past(enable) && $changed(baudClk)
      |-> $past(baseTick && kWrap))
    else $error("baud clock toggled off wrap");

  baud_tick_a: assert property (
    baudTick |-> $rose(baudClk))
    else $error("baud tick away from rising baud clock");

  // A stop in mid-phase clears the baud clock at once, so the hold ends.
  min_half_period_a: assert property (
    enable && $rose(baudClk) |=> (baudClk || !$past(enable)) [*3])
    else $error("baud half period shorter than four");

  // Dropping enable clears the flag even while the shift path is busy.
  status_clear_a: assert property (
    !enable |=> !txFlag_r)
    else $error("status not cleared in stop mode");

  status_follow_a: assert property (
    enable |=> txFlag_r == $past(txActive))
    else $error("status flag does not follow transmission");

  manchester_a: assert property (
    sending && !plainFmt |=> codedSerialOut == $past(shiftBit ^ baudClk_r))
    else $error("manchester output not shift xor baud");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  manchester_c: cover property (
    sending && !plainFmt ##1 $changed(codedSerialOut));

  plain_c: cover property (sending && plainFmt);

  baud_wrap_c: cover property ($rose(baudClk) ##[1:200] $fell(baudClk));

  prohibited_c: cover property (enable && !selLegal);

  stop_clear_c: cover property (txFlag_r && !enable ##1 !txFlag_r);

endmodule

/* File: include/mtc_pkg.sv */
package mtc_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] TX_STATUS_ADDR = 16'hff47;
  localparam logic [15:0] TX_CONTROL_ADDR = 16'hff4c;
  localparam logic [15:0] BASE_CLOCK_SELECT_ADDR = 16'hff4d;
  localparam logic [15:0] BAUD_DIVISOR_ADDR = 16'hff4e;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] TX_CONTROL_RST = 8'h10;
  localparam logic [7:0] BASE_CLOCK_SELECT_RST = 8'h00;
  localparam logic [7:0] BAUD_DIVISOR_RST = 8'h1f;
  localparam logic [7:0] TX_STATUS_RST = 8'h00;
  localparam logic [7:0] TX_CONTROL_MASK = 8'h93;
  localparam logic [7:0] BASE_CLOCK_SELECT_MASK = 8'h07;
  localparam logic [7:0] BAUD_DIVISOR_MASK = 8'h1f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OP_ENABLE_BIT = 7;
  localparam int FIRST_BIT_ORDER_BIT = 4;
  localparam int OUTPUT_FORMAT_BIT = 1;
  localparam int IDLE_LEVEL_BIT = 0;
  localparam int TX_IN_PROGRESS_BIT = 7;

  // ---------------------------------------------------------------
  // Divider constants
  // ---------------------------------------------------------------
  localparam logic [2:0] BASE_SEL_MAX = 3'h5;
  localparam logic [4:0] DIVISOR_MIN = 5'h05;
  localparam logic [4:0] K_FLOOR = 5'h04;
  localparam logic [4:0] PRESC_ONES = 5'h1f;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // ---------------------------------------------------------------
  // Processor-side access
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic bitWr;
    logic [2:0] bitSel;
    logic bitVal;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mtc_busreq_t;

endpackage

/* File: bench/mtc_rx_model.sv */
`timescale 1ns/1ps

// Remote receiver: samples the coded line and counts level changes.
module mtc_rx_model (
  // Clock and control.
  input wire logic core_clk,
  input wire logic clrCount,
  // Coded line.
  input wire logic lineIn,
  // Observation.
  output int edgeCount
);
  logic lastLevel;

  // The receiver tolerates any rate the sender picks.
  always_ff @(posedge core_clk) begin
    lastLevel <= lineIn;
    if (clrCount) begin
      edgeCount <= 0;
    end else if (lineIn !== lastLevel) begin
      edgeCount <= edgeCount + 1;
    end
  end
endmodule

/* File: bench/mtc_tx_config_tb.sv */
`timescale 1ns/1ps

module mtc_tx_config_tb;
  logic core_clk, srst, shiftBit, txActive, clrCount, b, s, o, f, i;
  mtc_pkg::mtc_busreq_t busReq;
  logic [7:0] busRdata;
  logic opEnable, firstBitLsb, baudClk, baudTick, codedSerialOut;
  int nFail, testsRun, edgeCount, t0, sel, dv, hits;
  int cyc = 0;

  mtc_tx_config u_mtc_tx_config (.core_clk(core_clk), .srst(srst),
    .busReq(busReq), .busRdata(busRdata), .shiftBit(shiftBit),
    .txActive(txActive), .opEnable(opEnable), .firstBitLsb(firstBitLsb),
    .baudClk(baudClk), .baudTick(baudTick),
    .codedSerialOut(codedSerialOut));

  mtc_rx_model u_mtc_rx_model (.core_clk(core_clk), .clrCount(clrCount),
    .lineIn(codedSerialOut), .edgeCount(edgeCount));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    testsRun++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic wrByte(input logic [15:0] a, input logic [7:0] d);
    busReq.addr = a;
    busReq.wdata = d;
    busReq.wr = 1'b1;
    step();
    busReq.wr = 1'b0;
    step();
  endtask

  task automatic wrBit(input logic [15:0] a, input logic [2:0] n,
                       input logic v);
    busReq.addr = a;
    busReq.bitSel = n;
    busReq.bitVal = v;
    busReq.bitWr = 1'b1;
    step();
    busReq.bitWr = 1'b0;
    step();
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
    busReq.addr = a;
    busReq.rd = 1'b1;
    step();
    busReq.rd = 1'b0;
    step();
    check(busRdata, e);
  endtask

  task automatic waitTick();
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (baudTick !== 1'b1 && n < 5000);
  endtask

  function automatic int kOf(input int d);
    return (d < 5) ? 4 : d;
  endfunction

  task automatic testDone();
    $display("counts: run=%0d fail=%0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(60000 * 40);
    nFail++;
    testDone();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    busReq = '0;
    {shiftBit, txActive, nFail, testsRun} = '0;
    srst = 1'b1;
    clrCount = 1'b1;
    void'($urandom(86));
    repeat (2) @(posedge core_clk);
    #1;
    srst = 1'b0;
    clrCount = 1'b0;
    rdChk(16'hff4c, 8'h10);
    rdChk(16'hff4d, 8'h00);
    rdChk(16'hff4e, 8'h1f);
    rdChk(16'hff47, 8'h00);
    rdChk(16'hff40, 8'h00);
    $display("reset test done");
    wrByte(16'hff4c, 8'h6c);
    rdChk(16'hff4c, 8'h00);
    wrByte(16'hff4d, 8'hff);
    rdChk(16'hff4d, 8'h07);
    wrBit(16'hff4d, 3'h1, 1'b0);
    rdChk(16'hff4d, 8'h07);
    wrByte(16'hff4e, 8'hff);
    wrBit(16'hff4e, 3'h0, 1'b0);
    rdChk(16'hff4e, 8'h1f);
    wrBit(16'hff4c, 3'h5, 1'b1);
    wrBit(16'hff4c, 3'h4, 1'b0);
    rdChk(16'hff4c, 8'h00);
    wrByte(16'hff4c, 8'h01);
    txActive = 1'b1;
    step();
    check(codedSerialOut, 1'b1);
    rdChk(16'hff47, 8'h00);
    txActive = 1'b0;
    $display("register test done");
    for (int t = 0; t < 9; t++) begin
      sel = (t == 0) ? 0 : (t == 1) ? 5 : (t == 8) ? 7 : $urandom_range(5, 0);
      dv = (t == 0) ? 0 : (t == 1) ? 31 : $urandom_range(31, 0);
      wrByte(16'hff4c, 8'h00);
      wrByte(16'hff4d, sel[7:0]);
      wrByte(16'hff4e, dv[7:0]);
      wrBit(16'hff4c, 3'h7, 1'b1);
      if (sel > 5) begin
        hits = 0;
        repeat (300) begin
          step();
          if (baudTick === 1'b1) hits++;
        end
        check(hits, 0);
      end else begin
        waitTick();
        t0 = cyc;
        waitTick();
        check(cyc - t0, (2 * kOf(dv)) << sel);
      end
    end
    $display("baud test done");
    for (int t = 0; t < 2; t++) begin
      i = $urandom;
      o = ~t[0];
      f = t[0];
      wrByte(16'hff4c, 8'h00);
      wrByte(16'hff4d, 8'h00);
      wrByte(16'hff4e, 8'h05);
      wrByte(16'hff4c, {1'b1, 2'b00, o, 2'b00, f, i});
      check(firstBitLsb, o);
      check(opEnable, 1'b1);
      clrCount = 1'b1;
      txActive = 1'b1;
      step();
      clrCount = 1'b0;
      repeat (60) begin
        s = $urandom;
        shiftBit = s;
        b = baudClk;
        step();
        check(codedSerialOut, f ? s : s ^ b);
      end
      check(edgeCount != 0, 1'b1);
      rdChk(16'hff47, 8'h80);
      txActive = 1'b0;
      step();
      step();
      check(codedSerialOut, i);
      txActive = 1'b1;
      wrByte(16'hff4c, 8'h00);
      rdChk(16'hff47, 8'h00);
      check(codedSerialOut, 1'b0);
      txActive = 1'b0;
    end
    $display("serial test done");
    testDone();
  end
endmodule
